// file: design/timer_params.svh
// constants for the channel delay and pulse timer: offsets, fields, resets, timing
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ==========================================================================
// register byte offsets on the wishbone bus
`define ADR_CLK_CTRL     8'h00
`define ADR_TIMER_DIV    8'h04
`define ADR_STATUS       8'h08
`define ADR_CH_BASE      8'h10
`define CH_STRIDE        8'h10
`define OFS_DELAY_COUNT  4'h0
`define OFS_PULSE_ON     4'h4
`define OFS_PULSE_OFF    4'h8

// ==========================================================================
// field positions
`define CLK_SEL_EXT_BIT  2
`define DIV_DELAY_LSB    0
`define DIV_PULSE_LSB    4
`define STAT_OUT_LSB     0
`define STAT_DELAY_LSB   4
`define STAT_PULSE_LSB   8

// ==========================================================================
// reset values
`define RST_CLK_CTRL     3'h0
`define RST_DIV_FIELD    4'h0
`define RST_COUNT        10'h000
// primed so the first oscillator tick lands on the first edge after release
`define RST_OSC_ACC      6'h0f

// ==========================================================================
// timing: internal oscillator period and reference clock period, in ns
`define OSC_PERIOD_NS    40
`define REF_PERIOD_NS    25
`define DIV_MAX_LOG2     4'h7

`endif

// file: design/timer_pkg.sv
// types shared by the channel delay and pulse timer design
`default_nettype none
package timer_pkg;
  typedef enum logic [2:0] {
    CH_IDLE      = 3'b000,
    CH_DELAY     = 3'b001,
    CH_PULSE_ON  = 3'b010,
    CH_PULSE_OFF = 3'b011,
    CH_STEADY    = 3'b100
  } chan_state_t;

  typedef logic [9:0] count_t;
  typedef logic [3:0] div_field_t;
  typedef logic [6:0] prescale_t;
endpackage : timer_pkg
`default_nettype wire

// file: design/channel_timer.sv
// one channel: captures settings at on-input rise, runs turn-on delay and pulse train
`include "timer_params.svh"
`default_nettype none
module channel_timer (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  on_level,
  input  wire logic                  on_rise,
  input  wire logic                  delay_tick,
  input  wire logic                  pulse_tick,
  input  wire timer_pkg::count_t     delay_cfg,
  input  wire timer_pkg::count_t     pulse_on_cfg,
  input  wire timer_pkg::count_t     pulse_off_cfg,
  output logic                       out_on,
  output timer_pkg::chan_state_t     state
);
  import timer_pkg::*;

  chan_state_t state_ff, nxt_state;
  count_t      cnt_ff, nxt_cnt;
  count_t      on_lat_ff, nxt_on_lat;
  count_t      off_lat_ff, nxt_off_lat;
  logic        out_ff, nxt_out;

  // ========================================================================
  // channel sequencer
  // falling input wins over everything so the current never outlives the frame
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_on_lat  = on_lat_ff;
    nxt_off_lat = off_lat_ff;
    nxt_out     = out_ff;
    if (!on_level) begin
      nxt_state = CH_IDLE;
      nxt_out   = 1'b0;
    end else if (on_rise) begin
      nxt_on_lat  = pulse_on_cfg;
      nxt_off_lat = pulse_off_cfg;
      if (delay_cfg == 10'h000) begin
        // zero delay: skip straight to the lit phase
        nxt_out = 1'b1;
        if (pulse_on_cfg == 10'h000 || pulse_off_cfg == 10'h000) begin
          nxt_state = CH_STEADY;
        end else begin
          nxt_state = CH_PULSE_ON;
          nxt_cnt   = pulse_on_cfg;
        end
      end else begin
        nxt_state = CH_DELAY;
        nxt_cnt   = delay_cfg;
        nxt_out   = 1'b0;
      end
    end else begin
      unique case (state_ff)
        CH_IDLE: begin
          nxt_out = 1'b0; // input high without a seen rise stays dark
        end
        CH_DELAY: begin
          if (delay_tick) begin
            if (cnt_ff == 10'h001) begin
              nxt_out = 1'b1;
              if (on_lat_ff == 10'h000 || off_lat_ff == 10'h000) begin
                nxt_state = CH_STEADY;
              end else begin
                nxt_state = CH_PULSE_ON;
                nxt_cnt   = on_lat_ff;
              end
            end else begin
              nxt_cnt = cnt_ff - 10'h001;
            end
          end
        end
        CH_PULSE_ON: begin
          if (pulse_tick) begin
            if (cnt_ff == 10'h001) begin
              nxt_state = CH_PULSE_OFF;
              nxt_cnt   = off_lat_ff;
              nxt_out   = 1'b0;
            end else begin
              nxt_cnt = cnt_ff - 10'h001;
            end
          end
        end
        CH_PULSE_OFF: begin
          if (pulse_tick) begin
            if (cnt_ff == 10'h001) begin
              nxt_state = CH_PULSE_ON;
              nxt_cnt   = on_lat_ff;
              nxt_out   = 1'b1;
            end else begin
              nxt_cnt = cnt_ff - 10'h001;
            end
          end
        end
        CH_STEADY: begin
          nxt_out = 1'b1;
        end
        default: begin
          nxt_state = CH_IDLE;
          nxt_out   = 1'b0;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= CH_IDLE;
      cnt_ff     <= `RST_COUNT;
      on_lat_ff  <= `RST_COUNT;
      off_lat_ff <= `RST_COUNT;
      out_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      on_lat_ff  <= nxt_on_lat;
      off_lat_ff <= nxt_off_lat;
      out_ff     <= nxt_out;
    end
  end

  assign out_on = out_ff;
  assign state  = state_ff;

  // ========================================================================
  // checks
  a_fall_forces_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n) !on_level |=> !out_ff)
    else $error("output still on after on-input fell");

  a_zero_delay_on: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (on_rise && on_level && delay_cfg == 10'h000) |=> out_ff)
    else $error("zero delay did not light output at once");

  a_delay_stays_dark: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (on_rise && on_level && delay_cfg != 10'h000) |=> (!out_ff && state_ff == CH_DELAY))
    else $error("output lit before delay expired");

  a_steady_zero_count: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state_ff == CH_STEADY) |-> (out_ff && (on_lat_ff == 10'h000 || off_lat_ff == 10'h000)))
    else $error("steady on with both pulse counts nonzero");

  a_latch_held: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !(on_rise && on_level) |=> $stable(on_lat_ff) && $stable(off_lat_ff))
    else $error("pulse counts changed outside a rising edge");
endmodule : channel_timer
`default_nettype wire

// file: design/channel_delay_pulse_timer.sv
// three-channel turn-on delay and pulse timer with a classic wishbone register slave
//
// Summary of operation
// - timer clock: internal oscillator or external, bit 2
// - delay is a 10-bit down-counter per channel
// - output lights once delay counter reaches zero
// - on-input falling edge switches output off always
// - longest undivided delay is 1023 timer periods
// - delay clock divided by power of two field
// - delay count captured at on-input rising edge
// - zero delay count means output lights immediately
// - two 10-bit counters set on and off time
// - pulse period is sum of the two counts
// - pulse clock has its own power-of-two divider
// - pulse counts captured at on-input rising edge
// - zero on or off count disables pulsing
// - delay and pulsing work in every power mode
// - settings writable anytime, active at next rise; dividers and clock select apply at once
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`include "timer_params.svh"
`default_nettype none
module channel_delay_pulse_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  channel_on_input,
  input  wire logic        ext_timer_clk,
  output logic      [2:0]  channel_out_enable
);
  import timer_pkg::*;

  // ========================================================================
  // helper functions
  // power-of-two divide mask; codes above seven clamp to the largest ratio
  function automatic prescale_t div_mask(input div_field_t field);
    div_field_t eff;
    eff = (field > `DIV_MAX_LOG2) ? `DIV_MAX_LOG2 : field;
    div_mask = prescale_t'((8'h01 << eff) - 8'h01);
  endfunction : div_mask

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] wr_merge(input logic [31:0] old_val,
                                           input logic [31:0] wr_val,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wr_val[b*8 +: 8];
      end
    end
    wr_merge = res;
  endfunction : wr_merge

  // channel index of a per-channel address, 2'h3 when not a channel register
  function automatic logic [1:0] ch_index(input logic [7:0] adr);
    logic [7:0] rel;
    rel = adr - `ADR_CH_BASE;
    if (adr >= `ADR_CH_BASE && rel < 8'(3 * `CH_STRIDE) && rel[3:0] <= `OFS_PULSE_OFF
        && rel[1:0] == 2'b00) begin
      ch_index = rel[5:4];
    end else begin
      ch_index = 2'h3;
    end
  endfunction : ch_index

  // ========================================================================
  // declarations
  logic [2:0]  clk_ctrl_ff, nxt_clk_ctrl;
  div_field_t  delay_div_ff, nxt_delay_div;
  div_field_t  pulse_div_ff, nxt_pulse_div;
  count_t      delay_cfg_ff [0:2];
  count_t      nxt_delay_cfg [0:2];
  count_t      pon_cfg_ff [0:2];
  count_t      nxt_pon_cfg [0:2];
  count_t      poff_cfg_ff [0:2];
  count_t      nxt_poff_cfg [0:2];
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;

  logic [2:0]  on_s1_ff, on_s2_ff, on_prev_ff;
  logic        ext_s1_ff, ext_s2_ff, ext_prev_ff;
  logic [5:0]  osc_acc_ff, nxt_osc_acc;
  logic        osc_tick_ff, nxt_osc_tick;
  prescale_t   pre_ff, nxt_pre;

  logic        timer_tick;
  logic        delay_tick;
  logic        pulse_tick;
  logic [2:0]  on_rise;
  logic [2:0]  ch_out;
  chan_state_t ch_state [0:2];
  logic        bus_req;
  logic [1:0]  req_ch;

  // ========================================================================
  // pin synchronisers: two flops, then an edge flop reading the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_s1_ff    <= 3'h0;
      on_s2_ff    <= 3'h0;
      on_prev_ff  <= 3'h0;
      ext_s1_ff   <= 1'b0;
      ext_s2_ff   <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      on_s1_ff    <= channel_on_input;
      on_s2_ff    <= on_s1_ff;
      on_prev_ff  <= on_s2_ff;
      ext_s1_ff   <= ext_timer_clk;
      ext_s2_ff   <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
    end
  end

  assign on_rise = on_s2_ff & ~on_prev_ff;

  // ========================================================================
  // internal oscillator: fractional accumulator gives the 40 ns period on average
  // jitter of one reference cycle is traded for needing no second clock
  always_comb begin
    nxt_osc_acc  = osc_acc_ff + 6'(`REF_PERIOD_NS);
    nxt_osc_tick = 1'b0;
    if (nxt_osc_acc >= 6'(`OSC_PERIOD_NS)) begin
      nxt_osc_acc  = nxt_osc_acc - 6'(`OSC_PERIOD_NS);
      nxt_osc_tick = 1'b1;
    end
  end

  // oscillator registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_acc_ff  <= `RST_OSC_ACC; // avoids two tickless cycles after release
      osc_tick_ff <= 1'b0;
    end else begin
      osc_acc_ff  <= nxt_osc_acc;
      osc_tick_ff <= nxt_osc_tick;
    end
  end

  // timer clock source; an external edge is only seen if it is slower than ref_clk
  assign timer_tick = clk_ctrl_ff[`CLK_SEL_EXT_BIT] ? (ext_s2_ff & ~ext_prev_ff)
                                                    : osc_tick_ff;

  // ========================================================================
  // shared prescaler; each divider picks its own ratio from it
  always_comb begin
    nxt_pre = timer_tick ? pre_ff + 7'h01 : pre_ff;
  end

  // prescaler register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 7'h00;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  assign delay_tick = timer_tick && ((pre_ff & div_mask(delay_div_ff)) == div_mask(delay_div_ff));
  assign pulse_tick = timer_tick && ((pre_ff & div_mask(pulse_div_ff)) == div_mask(pulse_div_ff));

  // ========================================================================
  // wishbone slave: one wait state, ack for one cycle, unmapped reads give zero
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign req_ch  = ch_index(wb_adr_i);

  always_comb begin
    nxt_clk_ctrl  = clk_ctrl_ff;
    nxt_delay_div = delay_div_ff;
    nxt_pulse_div = pulse_div_ff;
    nxt_delay_cfg = delay_cfg_ff;
    nxt_pon_cfg   = pon_cfg_ff;
    nxt_poff_cfg  = poff_cfg_ff;
    nxt_ack       = bus_req;
    nxt_rdat      = rdat_ff;
    if (bus_req) begin
      nxt_rdat = 32'h0000_0000;
      // channel count writes land in shadow settings only; channels copy them at a rise
      if (wb_we_i) begin
        if (wb_adr_i == `ADR_CLK_CTRL) begin
          nxt_clk_ctrl = 3'(wr_merge(32'(clk_ctrl_ff), wb_dat_i, wb_sel_i));
        end else if (wb_adr_i == `ADR_TIMER_DIV) begin
          nxt_delay_div = 4'(wr_merge(32'(delay_div_ff), wb_dat_i, wb_sel_i));
          nxt_pulse_div = 4'(wr_merge({24'h0, pulse_div_ff, 4'h0}, wb_dat_i, wb_sel_i) >> 4);
        end else if (req_ch != 2'h3) begin
          unique case (wb_adr_i[3:0])
            `OFS_DELAY_COUNT: nxt_delay_cfg[req_ch] =
              10'(wr_merge(32'(delay_cfg_ff[req_ch]), wb_dat_i, wb_sel_i));
            `OFS_PULSE_ON: nxt_pon_cfg[req_ch] =
              10'(wr_merge(32'(pon_cfg_ff[req_ch]), wb_dat_i, wb_sel_i));
            `OFS_PULSE_OFF: nxt_poff_cfg[req_ch] =
              10'(wr_merge(32'(poff_cfg_ff[req_ch]), wb_dat_i, wb_sel_i));
            default: nxt_rdat = 32'h0000_0000;
          endcase
        end
      end else begin
        if (wb_adr_i == `ADR_CLK_CTRL) begin
          nxt_rdat = 32'(clk_ctrl_ff);
        end else if (wb_adr_i == `ADR_TIMER_DIV) begin
          nxt_rdat = {24'h0, pulse_div_ff, delay_div_ff};
        end else if (wb_adr_i == `ADR_STATUS) begin
          for (int c = 0; c < 3; c++) begin
            nxt_rdat[`STAT_OUT_LSB + c]   = ch_out[c];
            nxt_rdat[`STAT_DELAY_LSB + c] = (ch_state[c] == CH_DELAY);
            nxt_rdat[`STAT_PULSE_LSB + c] = (ch_state[c] == CH_PULSE_ON) ||
                                            (ch_state[c] == CH_PULSE_OFF);
          end
        end else if (req_ch != 2'h3) begin
          unique case (wb_adr_i[3:0])
            `OFS_DELAY_COUNT: nxt_rdat = 32'(delay_cfg_ff[req_ch]);
            `OFS_PULSE_ON:    nxt_rdat = 32'(pon_cfg_ff[req_ch]);
            `OFS_PULSE_OFF:   nxt_rdat = 32'(poff_cfg_ff[req_ch]);
            default:          nxt_rdat = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // register file and bus answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctrl_ff  <= `RST_CLK_CTRL;
      delay_div_ff <= `RST_DIV_FIELD;
      pulse_div_ff <= `RST_DIV_FIELD;
      ack_ff       <= 1'b0;
      rdat_ff      <= 32'h0000_0000;
      for (int c = 0; c < 3; c++) begin
        delay_cfg_ff[c] <= `RST_COUNT;
        pon_cfg_ff[c]   <= `RST_COUNT;
        poff_cfg_ff[c]  <= `RST_COUNT;
      end
    end else begin
      clk_ctrl_ff  <= nxt_clk_ctrl;
      delay_div_ff <= nxt_delay_div;
      pulse_div_ff <= nxt_pulse_div;
      ack_ff       <= nxt_ack;
      rdat_ff      <= nxt_rdat;
      delay_cfg_ff <= nxt_delay_cfg;
      pon_cfg_ff   <= nxt_pon_cfg;
      poff_cfg_ff  <= nxt_poff_cfg;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ========================================================================
  // channels: the sequencer has no notion of power-control mode, so it runs in all
  for (genvar g = 0; g < 3; g++) begin : g_ch
    channel_timer u_ch (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .on_level      (on_s2_ff[g]),
      .on_rise       (on_rise[g]),
      .delay_tick    (delay_tick),
      .pulse_tick    (pulse_tick),
      .delay_cfg     (delay_cfg_ff[g]),
      .pulse_on_cfg  (pon_cfg_ff[g]),
      .pulse_off_cfg (poff_cfg_ff[g]),
      .out_on        (ch_out[g]),
      .state         (ch_state[g])
    );
  end

  assign channel_out_enable = ch_out;

  // ========================================================================
  // checks
  a_ack_one_cycle: assert property (
    @(posedge ref_clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_osc_no_gap: assert property (
    @(posedge ref_clk) disable iff (!rst_n) !osc_tick_ff |=> osc_tick_ff)
    else $error("oscillator tick missing two cycles running");

  a_tick_source: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_ctrl_ff[`CLK_SEL_EXT_BIT] && timer_tick) |-> (ext_s2_ff && !ext_prev_ff))
    else $error("external clock selected but tick not from its edge");

  a_div_one_passes: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (delay_div_ff == 4'h0) |-> (delay_tick == timer_tick))
    else $error("divide by one drops timer ticks");

  a_div_max_clamp: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (pulse_div_ff > 4'h7 && pulse_tick) |-> (pre_ff == 7'h7f))
    else $error("pulse divider above seven not clamped to 128");

  a_write_held: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_req && wb_we_i && wb_adr_i == `ADR_CH_BASE && wb_sel_i[0] && on_s2_ff[0])
    |=> (delay_cfg_ff[0][7:0] == $past(wb_dat_i[7:0])) && $stable(ch_out[0]))
    else $error("delay write lost or disturbed a running channel");
endmodule : channel_delay_pulse_timer
`default_nettype wire

// file: verif/display_ctrl_model.sv
// display controller model: drives the channel on-inputs and the external timer clock
`default_nettype none
module display_ctrl_model (
  input  wire logic       ref_clk,
  output logic      [2:0] channel_on_input,
  output logic            ext_timer_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_ff;

  // ==========================================================================
  // start values: all channels dark, timer clock low
  initial begin
    ph_ff = 2'h0;
    channel_on_input = 3'h0;
    ext_timer_clk = 1'b0;
  end

  // timer clock at 5 MHz, well under the ceiling the timer logic is built for
  always @(posedge ref_clk) begin
    ph_ff <= ph_ff + 2'h1;
    if (ph_ff == 2'h3) ext_timer_clk <= ~ext_timer_clk;
  end

  // one on-input level change; the bench keeps lows long enough to read as new rises
  task automatic drive(input int ch, input logic lvl);
    @(posedge ref_clk);
    // open-loop controller: no converter feedback, so no hold bit is needed
    channel_on_input[ch] <= lvl;
  endtask : drive
endmodule : display_ctrl_model
`default_nettype wire

// file: verif/channel_delay_pulse_timer_test.sv
// self-checking bench for the three-channel turn-on delay and pulse timer
`default_nettype none
module channel_delay_pulse_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} reg_row_t;
  typedef struct {int ch; logic [3:0] f; logic [9:0] c; int lo; int hi;} dly_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  channel_on_input;
  logic        ext_timer_clk;
  logic [2:0]  channel_out_enable;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] rd;
  // unused bits read 0, status is read-only, 0xfc is unmapped
  reg_row_t    rows[10] = '{'{8'h00, 32'h4, 32'h4}, '{8'h04, 32'hffff_ffa5, 32'ha5},
    '{8'h08, 32'hffff_ffff, 32'h0}, '{8'h10, 32'hffff_fdef, 32'h1ef},
    '{8'h14, 32'h155, 32'h155}, '{8'h20, 32'h3ff, 32'h3ff}, '{8'h24, 32'h2aa, 32'h2aa},
    '{8'h30, 32'h001, 32'h001}, '{8'h38, 32'h200, 32'h200}, '{8'hfc, 32'hffff_ffff, 32'h0}};
  // ticks every 8 cycles from the external clock; windows allow sync and tick phase
  dly_row_t    dly[6] = '{'{1, 4'h0, 10'd0, 2, 8}, '{0, 4'h0, 10'd5, 33, 50},
    '{2, 4'h1, 10'd5, 66, 100}, '{0, 4'h3, 10'd3, 130, 200},
    '{1, 4'hf, 10'd2, 1026, 2070}, '{2, 4'h7, 10'd2, 1026, 2070}};

  channel_delay_pulse_timer i_dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .channel_on_input,
    .ext_timer_clk, .channel_out_enable);
  display_ctrl_model i_ctrl (.ref_clk, .channel_on_input, .ext_timer_clk);

  // ==========================================================================
  // clock and hang guard
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================================
  // helpers
  task automatic summarize();
    $display("compared %0d, mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_span(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_span

  // one classic cycle; request held until the edge that sees ack, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // ack is looked at on rising edges only; the cycle limit ends a hang
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // cycles until output ch shows lvl, capped at lim
  task automatic meas(input int ch, input logic lvl, input int lim);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (channel_out_enable[ch] !== lvl && n < lim);
  endtask : meas

  // one off phase then one on phase of channel 2, lengths in ref cycles
  task automatic pulse_pair(input int off_len, input int on_len);
    meas(2, 1'b1, 100);
    chk_span(n, off_len - 1, off_len + 1);
    meas(2, 1'b0, 100);
    chk_span(n, on_len - 1, on_len + 1);
  endtask : pulse_pair

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    chk_word({28'h0, wb_ack_o, channel_out_enable}, 32'h0);
    rst_n <= 1'b1;
    // reset value, write, read back for each row
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0);
      chk_word(rd, 32'h0);
      wb(1'b1, rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0);
      chk_word(rd, rows[i].e);
    end
    // single byte lane write leaves the low byte alone
    wb(1'b1, 8'h10, 32'h0000_0200, 4'h2);
    wb(1'b0, 8'h10, 32'h0);
    chk_word(rd, 32'h2ef);
    // delay counts and dividers; pulse counts zero on one side keep outputs steady
    foreach (dly[i]) begin
      wb(1'b1, 8'h04, {24'h0, dly[i].f, dly[i].f});
      wb(1'b1, 8'h10 + 8'h10 * 8'(dly[i].ch), {22'h0, dly[i].c});
      i_ctrl.drive(dly[i].ch, 1'b1);
      meas(dly[i].ch, 1'b1, 2200);
      chk_span(n, dly[i].lo, dly[i].hi);
      repeat (20) @(negedge ref_clk);
      chk_word({31'h0, channel_out_enable[dly[i].ch]}, 32'h1);
      i_ctrl.drive(dly[i].ch, 1'b0);
      meas(dly[i].ch, 1'b0, 20);
      chk_span(n, 1, 6);
    end
    // falling input in mid-delay: output never lights
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h10, 32'd100);
    i_ctrl.drive(0, 1'b1);
    repeat (20) @(posedge ref_clk);
    wb(1'b1, 8'h10, 32'd1);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, 8'h08, 32'h0);
    chk_word(rd, 32'h10);
    i_ctrl.drive(0, 1'b0);
    meas(0, 1'b1, 900);
    chk_span(n, 900, 900);
    // internal oscillator, longest undivided delay: 1023 ticks at 5 per 8 cycles
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h10, 32'h3ff);
    i_ctrl.drive(0, 1'b1);
    meas(0, 1'b1, 1800);
    chk_span(n, 1625, 1655);
    i_ctrl.drive(0, 1'b0);
    // pulse train 3 on / 2 off; a write while on must not touch the running train
    wb(1'b1, 8'h00, 32'h4);
    wb(1'b1, 8'h30, 32'h0);
    wb(1'b1, 8'h34, 32'h3);
    wb(1'b1, 8'h38, 32'h2);
    i_ctrl.drive(2, 1'b1);
    meas(2, 1'b1, 10);
    chk_span(n, 2, 8);
    wb(1'b1, 8'h34, 32'h0);
    meas(2, 1'b0, 60);
    pulse_pair(16, 24);
    i_ctrl.drive(2, 1'b0);
    // keep the input low long enough to be seen as a fresh rise
    repeat (6) @(posedge ref_clk);
    i_ctrl.drive(2, 1'b1);
    meas(2, 1'b1, 10);
    meas(2, 1'b0, 100);
    chk_span(n, 100, 100);
    i_ctrl.drive(2, 1'b0);
    // pulse divider by 2, delay divider at 1; open loop, so ratios under 8 are legal
    wb(1'b1, 8'h34, 32'h3);
    wb(1'b1, 8'h04, 32'h10);
    i_ctrl.drive(2, 1'b1);
    meas(2, 1'b1, 10);
    meas(2, 1'b0, 100);
    pulse_pair(32, 48);
    i_ctrl.drive(2, 1'b0);
    summarize();
  end
endmodule : channel_delay_pulse_timer_test
`default_nettype wire
